//--- src/sdm_buf2.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Two-entry buffer, all outputs from flip-flops
module sdm_buf2 #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   // Filling side
   input  wire logic             i_in_valid,
   input  wire logic [WIDTH-1:0] i_in_data,
   output var  logic             o_in_ready,
   // Draining side
   output var  logic             o_out_valid,
   output var  logic [WIDTH-1:0] o_out_data,
   input  wire logic             i_out_ready
);
   logic [WIDTH-1:0] d1_q;   // Second slot
   logic             v1_q;   // Second slot valid
   logic             push;
   logic             pop;

   assign push = i_in_valid & o_in_ready;
   assign pop  = i_out_ready & o_out_valid;

   // Slot movement
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_out_valid <= 1'b0;
         o_out_data  <= '0;
         d1_q        <= '0;
         v1_q        <= 1'b0;
      end else if (pop) begin
         // Head leaves; second slot moves up
         if (v1_q) begin
            o_out_data <= d1_q;
            v1_q       <= 1'b0;
         end else if (push) begin
            o_out_data <= i_in_data;
         end else begin
            o_out_valid <= 1'b0;
         end
      end else if (push) begin
         // Fill the first free slot
         if (!o_out_valid) begin
            o_out_data  <= i_in_data;
            o_out_valid <= 1'b1;
         end else begin
            d1_q <= i_in_data;
            v1_q <= 1'b1;
         end
      end
   end

   // Ready while a slot stays free next cycle
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_in_ready <= 1'b0;
      end else begin
         o_in_ready <= !((v1_q && !pop) || (o_out_valid && push && !pop));
      end
   end
endmodule
`default_nettype wire

//--- src/sdm_cfg.svh
`ifndef SDM_CFG_SVH
`define SDM_CFG_SVH
// ==========================================================
// Sizes
`define SDM_BYTE_BITS      8
`define SDM_QUEUE_MAX      64
`define SDM_DEPTH_STEP     16
`define SDM_PATTERN_BITS   32
// ==========================================================
// Timing
`define SDM_CLK_HZ         25000000
`define SDM_BIT_DIV_RST    16'h00FA
`define SDM_DONE_BITS      8
// ==========================================================
// Reset values
`define SDM_PTR_RST        6'h00
`define SDM_CNT_RST        7'h00
`endif

//--- src/sdm_pkg.sv
// ==========================================================
// Shared types
package sdm_pkg;
   // Chip operating mode
   typedef enum logic [1:0] {
      SDM_SLEEP = 2'b00,
      SDM_STBY  = 2'b01,
      SDM_TX    = 2'b10,
      SDM_RX    = 2'b11
   } sdm_chip_mode_t;
   // Data path mode
   typedef enum logic [1:0] {
      SDM_CONT = 2'b00,
      SDM_BUF  = 2'b01,
      SDM_PKT  = 2'b10,
      SDM_PKT2 = 2'b11
   } sdm_data_mode_t;
endpackage

//--- src/sdm_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdm_cfg.svh"
module sdm_top #(
   parameter int QDEPTH = `SDM_QUEUE_MAX
) (
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   // Configuration
   input  wire logic [1:0]  i_chip_mode,
   input  wire logic [1:0]  i_data_mode,
   input  wire logic [15:0] i_bit_div,
   input  wire logic        i_bitsync_enable,
   input  wire logic        i_sync_detect_enable,
   input  wire logic [1:0]  i_sync_length_select,
   input  wire logic [1:0]  i_sync_error_tolerance,
   input  wire logic [31:0] i_sync_pattern_value,
   input  wire logic [1:0]  i_rx_event_select,
   input  wire logic        i_tx_start_nonempty,
   input  wire logic        i_fill_method,
   input  wire logic        i_fill_set,
   input  wire logic [1:0]  i_queue_depth_select,
   input  wire logic        i_overrun_clr,
   // Demodulator and modulator
   input  wire logic        i_demod_bit,
   input  wire logic        i_rssi_event,
   output var  logic        o_mod_bit,
   // Data pin and event pins
   input  wire logic        i_data_in,
   output var  logic        o_data_out,
   output var  logic        o_data_oe,
   output var  logic        o_event_a,
   output var  logic        o_event_b,
   // Byte write port
   input  wire logic        i_wr_valid,
   input  wire logic [7:0]  i_wr_byte,
   output var  logic        o_wr_ready,
   // Byte read port
   output var  logic        o_rd_valid,
   output var  logic [7:0]  o_rd_byte,
   input  wire logic        i_rd_ready,
   // Status
   output var  logic        o_queue_not_empty,
   output var  logic        o_queue_full,
   output var  logic        o_tx_done,
   output var  logic        o_overrun,
   output var  logic        o_sync_event
);
   // ==========================================================
   // Mode decode
   logic is_tx, is_rx, is_cont, is_buf, bitsync_on, sync_on;
   assign is_tx   = i_chip_mode == sdm_pkg::SDM_TX;
   assign is_rx   = i_chip_mode == sdm_pkg::SDM_RX;
   assign is_cont = i_data_mode == sdm_pkg::SDM_CONT;
   assign is_buf  = i_data_mode == sdm_pkg::SDM_BUF;
   // Synchronizer forced outside continuous mode
   assign bitsync_on = i_bitsync_enable | !is_cont;
   assign sync_on    = i_sync_detect_enable & bitsync_on;

   // Count of differing bits in a word
   function automatic logic [5:0] ones32(input logic [31:0] v);
      logic [5:0] n;
      n = '0;
      for (int k = 0; k < 32; k++) begin
         n = n + {5'h00, v[k]};
      end
      return n;
   endfunction

   // ==========================================================
   // Pin synchroniser and mode history
   logic       din_m_q, din_s_q;   // Two-stage data pin sync
   logic [1:0] mode_prev_q;        // Chip mode last cycle
   logic       mode_entry;         // Entering transmit, receive or sleep

   // Data pin passes two flops before use
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         din_m_q <= 1'b0;
         din_s_q <= 1'b0;
      end else begin
         din_m_q <= i_data_in;
         din_s_q <= din_m_q;
      end
   end

   // Remember mode to spot transitions
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         mode_prev_q <= 2'b00;
      end else begin
         mode_prev_q <= i_chip_mode;
      end
   end
   assign mode_entry = (i_chip_mode != mode_prev_q)
                     && (is_tx || is_rx
                         || i_chip_mode == sdm_pkg::SDM_SLEEP);

   // ==========================================================
   // Bit timer and data clock
   logic [15:0] bcnt_q;     // Position within the bit
   logic        bit_tick;   // End of bit: clock falls
   logic        half_tick;  // Middle of bit: clock rises
   logic        bit_rate_data_clock_q;     // Bit rate data clock

   assign bit_tick  = (is_tx | is_rx) && bcnt_q == i_bit_div - 16'h0001;
   assign half_tick = (is_tx | is_rx)
                    && bcnt_q == (i_bit_div >> 1) - 16'h0001;

   // Free counter while transmitting or receiving
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         bcnt_q <= 16'h0000;
      end else if (!(is_tx | is_rx) || bit_tick) begin
         bcnt_q <= 16'h0000;
      end else begin
         bcnt_q <= bcnt_q + 16'h0001;
      end
   end

   // Clock high in the second half of each bit
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         bit_rate_data_clock_q <= 1'b0;
      end else if (half_tick) begin
         bit_rate_data_clock_q <= 1'b1;
      end else if (bit_tick || !(is_tx | is_rx)) begin
         bit_rate_data_clock_q <= 1'b0;
      end
   end

   // ==========================================================
   // Receive sampling and sync detection
   logic        rx_bit_q;    // Bit taken at rising clock
   logic        rx_stb_q;    // One-cycle bit strobe
   logic [31:0] cmp_q;       // Compare register, newest at bit 0
   logic [5:0]  seen_q;      // Bits shifted, saturating
   logic [5:0]  plen;        // Pattern length in bits
   logic [31:0] pmask, pexp;
   logic        match;

   // Sample demodulator at each rising clock
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rx_bit_q <= 1'b0;
         rx_stb_q <= 1'b0;
      end else begin
         rx_stb_q <= half_tick & is_rx;
         if (half_tick & is_rx) begin
            rx_bit_q <= i_demod_bit;
         end
      end
   end

   // Continuous shift of received bits
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cmp_q  <= 32'h0000_0000;
         seen_q <= 6'h00;
      end else if (!(is_rx && sync_on)) begin
         seen_q <= 6'h00;
      end else if (rx_stb_q) begin
         cmp_q <= {cmp_q[30:0], rx_bit_q};
         if (seen_q != 6'h20) begin
            seen_q <= seen_q + 6'h01;
         end
      end
   end

   // Pattern top byte pairs with the oldest bit
   assign plen  = {1'b0, i_sync_length_select, 3'b000} + 6'h08;
   assign pmask = 32'hFFFF_FFFF >> (6'h20 - plen);
   assign pexp  = i_sync_pattern_value >> (6'h20 - plen);
   assign match = seen_q >= plen
                && ones32((cmp_q ^ pexp) & pmask)
                   <= {4'h0, i_sync_error_tolerance};

   // Sync event one cycle after each shift, judged on the shifted word
   logic shift_stb_q;   // Compare register took a bit last edge
   logic sync_stb_q;    // Sync event pulse
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         shift_stb_q <= 1'b0;
         sync_stb_q  <= 1'b0;
      end else begin
         shift_stb_q <= rx_stb_q;
         // Late judging would cost the first byte after the pattern
         sync_stb_q  <= shift_stb_q & is_rx & sync_on & match;
      end
   end
   assign o_sync_event = sync_stb_q;

   // ==========================================================
   // Byte queue
   logic [7:0] mem_q [QDEPTH];
   logic [5:0] wptr_q, rptr_q;
   logic [6:0] cnt_q, cnt_n, depth;
   logic       push, pop, qclear;
   logic [7:0] push_byte;
   logic       full;

   assign depth = {1'b0, i_queue_depth_select, 4'h0} + 7'h10;
   assign full  = cnt_q >= depth;

   // Pointer wrap at the programmed depth
   function automatic logic [5:0] nxt(input logic [5:0] p,
                                      input logic [6:0] d);
      return (p + 6'h01 == d[5:0]) ? 6'h00 : p + 6'h01;
   endfunction

   assign cnt_n = qclear ? 7'h00
                : cnt_q + {6'h00, push} - {6'h00, pop};

   // Store and pointer update
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         wptr_q <= `SDM_PTR_RST;
         rptr_q <= `SDM_PTR_RST;
         cnt_q  <= `SDM_CNT_RST;
      end else if (qclear) begin
         wptr_q <= `SDM_PTR_RST;
         rptr_q <= `SDM_PTR_RST;
         cnt_q  <= `SDM_CNT_RST;
      end else begin
         cnt_q <= cnt_n;
         if (push) begin
            wptr_q <= nxt(wptr_q, depth);
         end
         if (pop) begin
            rptr_q <= nxt(rptr_q, depth);
         end
      end
   end

   // Queue storage
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_q[wptr_q] <= push_byte;
      end
   end

   // Registered queue status
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_queue_not_empty <= 1'b0;
         o_queue_full      <= 1'b0;
         o_wr_ready        <= 1'b0;
      end else begin
         o_queue_not_empty <= cnt_n != 7'h00;
         o_queue_full      <= cnt_n >= depth;
         // Queue closed in continuous mode
         o_wr_ready <= is_buf && is_tx && cnt_n < depth;
      end
   end

   // ==========================================================
   // Buffered transmit serializer
   logic [7:0] ser_q;       // Byte on air, MSB first
   logic [3:0] left_q;      // Bits still to send
   logic       started_q;   // Start condition met
   logic       tx_pop, wr_push;

   assign wr_push = i_wr_valid & o_wr_ready;
   assign tx_pop  = is_buf && is_tx && bit_tick && started_q
                  && left_q <= 4'h1 && cnt_q != 7'h00;

   // Start once non-empty or once full
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         started_q <= 1'b0;
      end else if (!(is_buf && is_tx)) begin
         started_q <= 1'b0;
      end else if (i_tx_start_nonempty ? cnt_q != 7'h00 : full) begin
         started_q <= 1'b1;
      end
   end

   // Shift out and reload while bytes remain
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ser_q  <= 8'h00;
         left_q <= 4'h0;
      end else if (!(is_buf && is_tx)) begin
         left_q <= 4'h0;
      end else if (bit_tick) begin
         if (tx_pop) begin
            ser_q  <= mem_q[rptr_q];
            left_q <= 4'h8;
         end else if (left_q != 4'h0) begin
            ser_q  <= {ser_q[6:0], 1'b0};
            left_q <= left_q - 4'h1;
         end
      end
   end

   // Done when the last bit has left
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_tx_done <= 1'b0;
      end else if (!(is_buf && is_tx) || tx_pop) begin
         o_tx_done <= 1'b0;
      end else if (bit_tick && left_q == 4'h1) begin
         o_tx_done <= 1'b1;
      end
   end

   // ==========================================================
   // Buffered receive deserializer
   logic [7:0] des_q;     // Assembling byte
   logic [3:0] dcnt_q;    // Bits assembled
   logic       fill_q;    // Filling started by sync
   logic       filling, byte_done, rx_push, rd_pop, buf_ready;

   assign filling   = is_buf && is_rx
                    && (i_fill_method ? i_fill_set : fill_q);
   assign byte_done = filling && rx_stb_q && dcnt_q == 4'h7;
   assign rx_push   = byte_done && !full;

   // Sync-triggered fill holds until receive ends
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         fill_q <= 1'b0;
      end else if (!(is_buf && is_rx)) begin
         fill_q <= 1'b0;
      end else if (sync_stb_q) begin
         fill_q <= 1'b1;
      end
   end

   // Assemble bits MSB first
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         des_q  <= 8'h00;
         dcnt_q <= 4'h0;
      end else if (!filling) begin
         dcnt_q <= 4'h0;
      end else if (rx_stb_q) begin
         des_q  <= {des_q[6:0], rx_bit_q};
         dcnt_q <= (dcnt_q == 4'h7) ? 4'h0 : dcnt_q + 4'h1;
      end
   end

   // Overrun: set wins over clear, clear also empties queue
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_overrun <= 1'b0;
      end else if (byte_done && full) begin
         o_overrun <= 1'b1;
      end else if (i_overrun_clr) begin
         o_overrun <= 1'b0;
      end
   end

   assign rd_pop    = is_buf && !is_tx && cnt_q != 7'h00 && buf_ready;
   assign push      = wr_push | rx_push;
   assign pop       = tx_pop | rd_pop;
   assign push_byte = is_tx ? i_wr_byte : {des_q[6:0], rx_bit_q};
   assign qclear    = mode_entry | (i_overrun_clr & !(byte_done & full));

   // Read path keeps words through a host stall
   sdm_buf2 #(
      .WIDTH (8)
   ) u_rd_buf (
      .i_clk       (i_clk),
      .i_rst       (i_rst),
      .i_in_valid  (rd_pop),
      .i_in_data   (mem_q[rptr_q]),
      .o_in_ready  (buf_ready),
      .o_out_valid (o_rd_valid),
      .o_out_data  (o_rd_byte),
      .i_out_ready (i_rd_ready)
   );

   // ==========================================================
   // Continuous mode pins
   logic tx_samp_q;   // Host bit taken at rising clock

   // Sample host data pin on rising clock
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         tx_samp_q <= 1'b0;
      end else if (half_tick && is_tx) begin
         tx_samp_q <= din_s_q;
      end
   end

   // Modulator bit per mode
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_mod_bit <= 1'b0;
      end else if (!is_tx) begin
         o_mod_bit <= 1'b0;
      end else if (is_cont) begin
         o_mod_bit <= tx_samp_q;
      end else begin
         o_mod_bit <= ser_q[7] & (left_q != 4'h0);
      end
   end

   // Data pin drive and content
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_data_out <= 1'b0;
         o_data_oe  <= 1'b0;
      end else begin
         o_data_oe <= is_cont & is_rx;
         if (!(is_cont & is_rx)) begin
            o_data_out <= 1'b0;
         end else if (!i_bitsync_enable) begin
            o_data_out <= i_demod_bit;
         end else if (o_event_b && !bit_rate_data_clock_q) begin
            // Change with the falling clock pin, host samples on rising
            o_data_out <= rx_bit_q;
         end
      end
   end

   // Event pins in continuous mode
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_event_a <= 1'b0;
         o_event_b <= 1'b0;
      end else begin
         // Clock out in transmit, or receive with synchronizer
         o_event_b <= is_cont && (is_tx || (is_rx && i_bitsync_enable))
                      && bit_rate_data_clock_q;
         if (!(is_cont && is_rx)) begin
            o_event_a <= 1'b0;
         end else if (i_rx_event_select == 2'b00) begin
            o_event_a <= sync_stb_q;
         end else if (i_rx_event_select == 2'b01) begin
            o_event_a <= i_rssi_event;
         end else begin
            o_event_a <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

//--- test/sdm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ========
// Host side of the byte ports
module sdm_host_model (
   // Clock
   input  wire logic       i_clk,
   // Write port
   output var  logic       o_wr_valid,
   output var  logic [7:0] o_wr_byte,
   input  wire logic       i_wr_ready,
   // Read port
   input  wire logic       i_rd_valid,
   input  wire logic [7:0] i_rd_byte,
   output var  logic       o_rd_ready
);
   initial begin
      o_wr_valid = 1'b0;
      o_wr_byte = 8'hA5;
      o_rd_ready = 1'b0;
   end
   // Every framing byte comes from the host, held until taken
   task automatic put_bytes(input logic [7:0] q[$]);
      o_wr_valid = 1'b1;
      foreach (q[i]) begin
         o_wr_byte = q[i];
         while (i_wr_ready !== 1'b1) @(posedge i_clk) #1;
         @(posedge i_clk) #1;
      end
      o_wr_valid = 1'b0;
      o_wr_byte = ~o_wr_byte;
   endtask
   // Stall a while, then drain one byte
   task automatic get_byte(input int stall, output logic [7:0] b);
      repeat (stall) @(posedge i_clk) #1;
      o_rd_ready = 1'b1;
      while (i_rd_valid !== 1'b1) @(posedge i_clk) #1;
      b = i_rd_byte;
      @(posedge i_clk) #1;
      o_rd_ready = 1'b0;
   endtask
endmodule
`default_nettype wire

//--- test/sdm_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ========
// Bench of the sync detector and data modes
module sdm_top_bench;
   // Design inputs
   logic        i_clk, i_rst, i_bitsync_enable, i_sync_detect_enable;
   logic        i_tx_start_nonempty, i_demod_bit, i_rssi_event;
   logic        i_wr_valid, i_rd_ready, i_data_in, i_overrun_clr;
   logic [1:0]  i_chip_mode, i_data_mode, i_sync_length_select;
   logic [1:0]  i_sync_error_tolerance, i_rx_event_select;
   logic [1:0]  i_queue_depth_select;
   logic [31:0] i_sync_pattern_value;
   logic [7:0]  i_wr_byte, o_rd_byte, b;
   // Design outputs
   logic        o_mod_bit, o_data_out, o_data_oe, o_event_a, o_event_b;
   logic        o_wr_ready, o_rd_valid, o_tx_done, o_queue_not_empty;
   logic        o_queue_full, o_overrun, o_sync_event;
   // Bookkeeping
   int          num_errors, compares, hits, ev;
   integer      seed;
   logic [7:0]  q[$];
   // Bit period fixed at 8 cycles, 320 ns
   sdm_top dut (
      .i_clk, .i_rst, .i_chip_mode, .i_data_mode, .i_bit_div(16'h0008),
      .i_bitsync_enable, .i_sync_detect_enable, .i_sync_length_select,
      .i_sync_error_tolerance, .i_sync_pattern_value, .i_rx_event_select,
      .i_tx_start_nonempty, .i_fill_method(1'b0), .i_fill_set(1'b0),
      .i_queue_depth_select, .i_overrun_clr, .i_demod_bit,
      .i_rssi_event, .o_mod_bit, .i_data_in, .o_data_out,
      .o_data_oe, .o_event_a, .o_event_b, .i_wr_valid, .i_wr_byte,
      .o_wr_ready, .o_rd_valid, .o_rd_byte, .i_rd_ready,
      .o_queue_not_empty, .o_queue_full, .o_tx_done, .o_overrun,
      .o_sync_event
   );
   sdm_host_model host (
      .i_clk, .o_wr_valid(i_wr_valid), .o_wr_byte(i_wr_byte),
      .i_wr_ready(o_wr_ready), .i_rd_valid(o_rd_valid),
      .i_rd_byte(o_rd_byte), .o_rd_ready(i_rd_ready)
   );
   // 25 MHz clock
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end
   // Pulse counters, sampled away from the rising edge
   always @(negedge i_clk) begin
      hits += (o_sync_event === 1'b1);
      ev += (o_event_a === 1'b1);
   end
   // Drive point just after a rising edge
   task automatic step(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   // Compare one value
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Hold each demodulated bit one bit period, first bit on top
   task automatic send_bits(input logic [31:0] v, input int n);
      for (int k = n - 1; k >= 0; k--) begin
         i_demod_bit = v[k];
         step(8);
      end
   endtask
   // Buffered transmit of n random bytes, stream checked bit by bit
   task automatic tx_run(input int n, input logic ne);
      i_tx_start_nonempty = ne;
      i_chip_mode = 2'b10;
      step(2);
      q.delete();
      repeat (n) q.push_back(8'($random(seed)));
      host.put_bytes(q);
      while ((ne ? o_queue_not_empty : o_queue_full) !== 1'b1) step(1);
      if (!ne) check(8'(o_wr_ready), 8'h00);
      while ((ne ? o_queue_not_empty : o_queue_full) !== 1'b0) step(1);
      step(3);
      foreach (q[i]) for (int k = 7; k >= 0; k--) begin
         check(8'(o_mod_bit), 8'(q[i][k]));
         check(8'(o_tx_done), 8'h00);
         step(8);
      end
      check(8'(o_tx_done), 8'h01);
      step(8);
      i_chip_mode = 2'b01;
      step(2);
   endtask
   // Verdict
   task automatic tally_and_finish;
      $display("compares=%0d num_errors=%0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Watchdog, well past the roughly 15000 cycles the tests need
   initial begin
      #1600000;
      num_errors++;
      tally_and_finish;
   end
   initial begin
      {i_bitsync_enable, i_sync_detect_enable, i_demod_bit} = 3'h0;
      {i_tx_start_nonempty, i_rssi_event, i_overrun_clr} = 3'h0;
      i_data_in = 1'b1;
      {i_chip_mode, i_rx_event_select, i_queue_depth_select} = 6'h00;
      {i_sync_length_select, i_sync_error_tolerance} = 4'h0;
      i_data_mode = 2'b01;
      i_sync_pattern_value = 32'h2DB4_C387;
      seed = 32'h464715D2;
      i_rst = 1'b1;
      step(16);
      i_rst = 1'b0;
      step(2);
      // Full start at every depth, then non-empty start
      for (int d = 0; d < 4; d++) begin
         i_queue_depth_select = 2'(d);
         tx_run(16 * (d + 1), 1'b0);
      end
      tx_run(1, 1'b1);
      // Buffered receive, sync with one bit wrong, 16 byte queue
      i_sync_detect_enable = 1'b1;
      i_sync_error_tolerance = 2'b01;
      i_queue_depth_select = 2'b00;
      i_chip_mode = 2'b11;
      hits = 0;
      step(2);
      send_bits(32'h0, 16);
      send_bits(32'h2C, 8);
      q.delete();
      repeat (3) q.push_back(8'($random(seed)));
      foreach (q[i]) send_bits({24'h0, q[i]}, 8);
      check(8'(hits != 0), 8'h01);
      foreach (q[i]) begin
         host.get_byte(1 + ($random(seed) & 3), b);
         check(b, q[i]);
      end
      // No reads: queue and read buffer fill, then overrun
      check(8'(o_overrun), 8'h00);
      step(1400);
      check(8'(o_overrun), 8'h01);
      check(8'(o_queue_full), 8'h01);
      // Continuous receive, each length and event select
      i_data_mode = 2'b00;
      // Clear pulse drops the flag and empties the queue
      i_overrun_clr = 1'b1;
      step(1);
      i_overrun_clr = 1'b0;
      step(1);
      check(8'(o_overrun), 8'h00);
      check(8'(o_queue_not_empty), 8'h00);
      i_bitsync_enable = 1'b1;
      i_sync_error_tolerance = 2'b00;
      i_rssi_event = 1'b1;
      for (int l = 0; l < 4; l++) begin
         i_sync_length_select = 2'(l);
         i_rx_event_select = 2'(l);
         send_bits(32'h0, 32);
         hits = 0;
         ev = 0;
         send_bits(32'h2DB4_C387 >> (8 * (3 - l)), 8 * (l + 1));
         step(4);
         check(8'(hits), 8'h01);
         check(l == 1 ? 8'(o_event_a) : 8'(ev), 8'(l < 2));
      end
      // Synchronizer off: raw data, no clock, no detection
      i_bitsync_enable = 1'b0;
      i_sync_length_select = 2'b00;
      step(24);
      hits = 0;
      send_bits(32'h2D, 8);
      check(8'(hits), 8'h00);
      check(8'(o_data_out), 8'(i_demod_bit));
      check(8'(o_event_b), 8'h00);
      // Continuous transmit: host bits follow the data clock
      i_chip_mode = 2'b10;
      for (int k = 0; k < 16; k++) begin
         while (o_event_b !== 1'b1) step(1);
         while (o_event_b !== 1'b0) step(1);
         i_data_in = 1'($random(seed));
         while (o_event_b !== 1'b1) step(1);
         step(1);
         check(8'(o_mod_bit), 8'(i_data_in));
      end
      tally_and_finish;
   end
endmodule
`default_nettype wire

//--- test/sdm_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ========
// Port checks of the data path
module sdm_top_chk (
   // Clock and reset
   input wire logic       i_clk,
   input wire logic       i_rst,
   // Watched inputs
   input wire logic [1:0] i_chip_mode,
   input wire logic [1:0] i_data_mode,
   input wire logic       i_bitsync_enable,
   input wire logic       i_sync_detect_enable,
   input wire logic       i_wr_valid,
   input wire logic       i_overrun_clr,
   // Watched outputs
   input wire logic       o_wr_ready,
   input wire logic       o_queue_not_empty,
   input wire logic       o_queue_full,
   input wire logic       o_tx_done,
   input wire logic       o_sync_event,
   input wire logic       o_event_a,
   input wire logic       o_event_b,
   input wire logic       o_data_oe
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // Mode decodes
   wire logic buf_tx = i_chip_mode == 2'b10 && i_data_mode == 2'b01;
   wire logic cont_rx = i_chip_mode == 2'b11 && i_data_mode == 2'b00;
   wire logic det_on = i_sync_detect_enable
                       && (i_bitsync_enable || i_data_mode != 2'b00);
   // ========
   // Settled conditions
   sequence s_cont_rx; cont_rx [*3]; endsequence
   sequence s_not_cont; (i_data_mode != 2'b00) [*3]; endsequence
   sequence s_det_off; (!det_on) [*3]; endsequence
   AST_WR_READY_MODE: assert property (!buf_tx |=> !o_wr_ready)
      else $error("write ready outside buffered transmit");
   AST_EVENTS_OFF: assert property (
      s_not_cont |=> !o_event_a && !o_event_b)
      else $error("event pins active outside continuous mode");
   AST_OE_CONT_RX: assert property (s_cont_rx |=> o_data_oe)
      else $error("data pin not driven in continuous receive");
   AST_SYNC_GATED: assert property (s_det_off |=> !o_sync_event)
      else $error("sync event while detection disabled");
   AST_SYNC_PULSE: assert property (
      o_sync_event |=> !o_sync_event)
      else $error("sync event longer than one cycle");
   AST_FULL_REFUSE: assert property (
      o_queue_full |-> !o_wr_ready)
      else $error("write ready while queue full");
   AST_NOT_EMPTY: assert property (
      i_wr_valid && o_wr_ready && !i_overrun_clr |=> o_queue_not_empty)
      else $error("accepted byte left queue empty");
   AST_DONE_EMPTY: assert property (
      $rose(o_tx_done) |-> !o_queue_not_empty)
      else $error("transmit done with bytes queued");
endmodule
bind sdm_top sdm_top_chk chk (
   .i_clk, .i_rst, .i_chip_mode, .i_data_mode, .i_bitsync_enable,
   .i_sync_detect_enable, .i_wr_valid, .i_overrun_clr, .o_wr_ready,
   .o_queue_not_empty, .o_queue_full, .o_tx_done, .o_sync_event,
   .o_event_a, .o_event_b, .o_data_oe
);
`default_nettype wire
